// ### shared/dml_params.svh
`ifndef DML_PARAMS_SVH
`define DML_PARAMS_SVH

// Register offsets on the serial control bus.
`define DML_OFS_DUAL_RX_CTL     8'h34
`define DML_OFS_STRAP_STATUS    8'h37
`define DML_OFS_AUDIO_DIV       8'h3A
`define DML_OFS_EQUALIZER_SETTING_STATUS       8'h3B
`define DML_OFS_LINK_ERR        8'h41
`define DML_OFS_EQ_BYPASS       8'h44

// Strap decode status fields.
`define DML_BC_LATCHED_BIT      7
`define DML_BC_CODE_MSB         6
`define DML_BC_CODE_LSB         4
`define DML_OUT_LATCHED_BIT     3
`define DML_OUT_CODE_MSB        2
`define DML_OUT_CODE_LSB        0

// Audio divider fields.
`define DML_AUD_OV_BIT          7
`define DML_AUD_DIV_MSB         6
`define DML_AUD_DIV_LSB         4
`define DML_REF_OV_BIT          2
`define DML_REF_DIV_MSB         1
`define DML_REF_DIV_LSB         0
`define DML_AUD_DIV_RESET       8'h00

// Link error control fields.
`define DML_ERR_EN_BIT          4
`define DML_ERR_THR_MSB         3
`define DML_ERR_THR_LSB         0
`define DML_LINK_ERR_RESET      8'h03

// Port select and equalizer bypass fields.
`define DML_PORT0_SEL_BIT       0
`define DML_SECOND_PORT_SELECT_BIT       1
`define DML_DUAL_RX_RESET       8'h01
`define DML_EQ_BYPASS_RESET     8'h60
`define DML_EQ_OFF_BIT          0
`define DML_EQ_ST1_MSB          7
`define DML_EQ_ST1_LSB          5
`define DML_EQ_ST2_MSB          3
`define DML_EQ_ST2_LSB          1

`endif

// ### shared/dml_pkg.sv
package dml_pkg;

    // Back-channel strap decode: rate and cable.
    typedef enum logic [2:0]
    {
        DML_BC_5M_STP  = 3'h0,
        DML_BC_5M_COAX = 3'h1,
        DML_BC_20M_STP = 3'h2,
        DML_BC_20M_CX  = 3'h3,
        DML_BC_5M_STP2 = 3'h4,
        DML_BC_5M_CX2  = 3'h5,
        DML_BC_20M_ST2 = 3'h6,
        DML_BC_20M_CX2 = 3'h7
    } dml_bc_code_t;

    // Link lock state.
    typedef enum logic [1:0]
    {
        DML_UNLOCKED = 2'b01,
        DML_LOCKED   = 2'b10
    } dml_lock_state_t;

endpackage

// ### hw/dml_err_counter.sv
`timescale 1ns/1ps
`include "dml_params.svh"

module dml_err_counter
(
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       clear_i,
    input  wire logic       count_en_i,
    input  wire logic       err_i,
    input  wire logic [3:0] thr_i,
    output logic            trip_o,
    output logic [3:0]      count_o
);
    import dml_pkg::*;

    logic [3:0] count_reg;
    logic [4:0] sum;

    // Saturating increment, trips when the sum reaches the threshold.
    assign sum     = {1'b0, count_reg} + 5'h01;
    assign trip_o  = err_i &&
                     (!count_en_i || sum >= {1'b0, thr_i});
    assign count_o = count_reg;

    // Accumulate errors; cleared on disable or lost lock.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            count_reg <= 4'h0;
        else if (clear_i || !count_en_i)
            count_reg <= 4'h0;
        else if (err_i && sum < 5'h10)
            count_reg <= sum[3:0];
    end

endmodule // dml_err_counter

// ### hw/dml_mode_eq_regs.sv
`timescale 1ns/1ps
`include "dml_params.svh"

module dml_mode_eq_regs
(
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic [7:0]      REG_RDATA_O,
    output logic            REG_RVALID_O,
    input  wire logic       BC_STRAP_VALID_I,
    input  wire logic [2:0] BC_STRAP_CODE_I,
    input  wire logic       OUT_STRAP_VALID_I,
    input  wire logic [2:0] OUT_STRAP_CODE_I,
    input  wire logic [2:0] AUTO_AUD_DIV_I,
    input  wire logic [1:0] AUTO_REF_DIV_I,
    output logic [2:0]      AUD_DIV_SEL_O,
    output logic [5:0]      AUD_DIV_RATIO_O,
    output logic [1:0]      REF_DIV_SEL_O,
    output logic [3:0]      REF_DIV_RATIO_O,
    input  wire logic [5:0] AEQ0_SETTING_I,
    input  wire logic [5:0] AEQ1_SETTING_I,
    output logic [5:0]      EQ0_APPLIED_O,
    output logic [5:0]      EQ1_APPLIED_O,
    output logic            AEQ0_ENABLE_O,
    output logic            AEQ1_ENABLE_O,
    input  wire logic       SYNC_GAIN_I,
    input  wire logic       CLK0_ERR_I,
    input  wire logic       CLK1_ERR_I,
    input  wire logic       DCB_ERR_I,
    output logic            LOCK_O
);
    import dml_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0]      strap_reg;
    logic [7:0]      aud_div_reg;
    logic [7:0]      link_err_reg;
    logic [7:0]      dual_rx_reg;
    logic [7:0]      byp0_reg;
    logic [7:0]      byp1_reg;
    logic [7:0]      rdata_reg;
    logic            rvalid_reg;
    logic [7:0]      rdata_next;
    dml_lock_state_t lock_reg;
    logic            second_port_select;
    logic            wr_link;
    logic            err_any;
    logic            trip;
    logic [3:0]      err_count;

    // Oscillator divide from the three-bit ratio code.
    function automatic logic [5:0] aud_ratio(input logic [2:0] code);
        case (code)
            3'h0:    aud_ratio = 6'h20;
            3'h1:    aud_ratio = 6'h10;
            3'h2:    aud_ratio = 6'h08;
            3'h3:    aud_ratio = 6'h04;
            3'h4,
            3'h5:    aud_ratio = 6'h02;
            default: aud_ratio = 6'h01;
        endcase
    endfunction

    // Equalizer setting from bypass register fields, stage two high.
    function automatic logic [5:0] eq_manual(input logic [7:0] byp);
        eq_manual = {byp[`DML_EQ_ST2_MSB:`DML_EQ_ST2_LSB],
                     byp[`DML_EQ_ST1_MSB:`DML_EQ_ST1_LSB]};
    endfunction

    assign second_port_select = dual_rx_reg[`DML_SECOND_PORT_SELECT_BIT];
    assign wr_link   = REG_WR_I && REG_ADDR_I == `DML_OFS_LINK_ERR;

    ////////////////////////////////////////////////////////////////////////
    // Strap capture: code and done flag latch once after reset.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            strap_reg <= 8'h00;
        else
        begin
            if (BC_STRAP_VALID_I && !strap_reg[`DML_BC_LATCHED_BIT])
            begin
                strap_reg[`DML_BC_CODE_MSB:`DML_BC_CODE_LSB]
                    <= BC_STRAP_CODE_I;
                strap_reg[`DML_BC_LATCHED_BIT] <= 1'b1;
            end
            if (OUT_STRAP_VALID_I && !strap_reg[`DML_OUT_LATCHED_BIT])
            begin
                strap_reg[`DML_OUT_CODE_MSB:`DML_OUT_CODE_LSB]
                    <= OUT_STRAP_CODE_I;
                strap_reg[`DML_OUT_LATCHED_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared writable registers; bit 3 of the divider is reserved.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            aud_div_reg  <= `DML_AUD_DIV_RESET;
            link_err_reg <= `DML_LINK_ERR_RESET;
            dual_rx_reg  <= `DML_DUAL_RX_RESET;
        end
        else if (REG_WR_I)
        begin
            if (REG_ADDR_I == `DML_OFS_AUDIO_DIV)
                aud_div_reg <= REG_WDATA_I & 8'hF7;
            if (wr_link)
                link_err_reg <= REG_WDATA_I & 8'h1F;
            if (REG_ADDR_I == `DML_OFS_DUAL_RX_CTL)
                dual_rx_reg <= REG_WDATA_I & 8'h03;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port bypass registers, steered by the port select bits.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            byp0_reg <= `DML_EQ_BYPASS_RESET;
            byp1_reg <= `DML_EQ_BYPASS_RESET;
        end
        else if (REG_WR_I && REG_ADDR_I == `DML_OFS_EQ_BYPASS)
        begin
            if (second_port_select)
                byp1_reg <= REG_WDATA_I & 8'hEF;
            else if (dual_rx_reg[`DML_PORT0_SEL_BIT])
                byp0_reg <= REG_WDATA_I & 8'hEF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider selection with override or automatic choice.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            AUD_DIV_SEL_O   <= 3'h0;
            AUD_DIV_RATIO_O <= 6'h20;
            REF_DIV_SEL_O   <= 2'h0;
            REF_DIV_RATIO_O <= 4'h1;
        end
        else
        begin
            if (aud_div_reg[`DML_AUD_OV_BIT])
            begin
                AUD_DIV_SEL_O   <= aud_div_reg[`DML_AUD_DIV_MSB:
                                               `DML_AUD_DIV_LSB];
                AUD_DIV_RATIO_O <= aud_ratio(aud_div_reg[`DML_AUD_DIV_MSB:
                                             `DML_AUD_DIV_LSB]);
            end
            else
            begin
                AUD_DIV_SEL_O   <= AUTO_AUD_DIV_I;
                AUD_DIV_RATIO_O <= aud_ratio(AUTO_AUD_DIV_I);
            end
            if (aud_div_reg[`DML_REF_OV_BIT])
            begin
                REF_DIV_SEL_O   <= aud_div_reg[`DML_REF_DIV_MSB:
                                               `DML_REF_DIV_LSB];
                REF_DIV_RATIO_O <= 4'h1 << aud_div_reg[`DML_REF_DIV_MSB:
                                   `DML_REF_DIV_LSB];
            end
            else
            begin
                REF_DIV_SEL_O   <= AUTO_REF_DIV_I;
                REF_DIV_RATIO_O <= 4'h1 << AUTO_REF_DIV_I;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Equalizer setting applied to each analog front end.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            EQ0_APPLIED_O <= 6'h00;
            EQ1_APPLIED_O <= 6'h00;
        end
        else
        begin
            EQ0_APPLIED_O <= byp0_reg[`DML_EQ_OFF_BIT] ?
                             eq_manual(byp0_reg) : AEQ0_SETTING_I;
            EQ1_APPLIED_O <= byp1_reg[`DML_EQ_OFF_BIT] ?
                             eq_manual(byp1_reg) : AEQ1_SETTING_I;
        end
    end

    assign AEQ0_ENABLE_O = !byp0_reg[`DML_EQ_OFF_BIT];
    assign AEQ1_ENABLE_O = !byp1_reg[`DML_EQ_OFF_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Link error monitor over both clocks and the balanced stream.
    assign err_any = CLK0_ERR_I || CLK1_ERR_I || DCB_ERR_I;

    dml_err_counter i_dml_err_counter
    (
        .CLK_I      (CLK_I),
        .RST_N_I    (RST_N_I),
        .clear_i    (lock_reg != DML_LOCKED),
        .count_en_i (link_err_reg[`DML_ERR_EN_BIT]),
        .err_i      (err_any && lock_reg == DML_LOCKED),
        .thr_i      (link_err_reg[`DML_ERR_THR_MSB:`DML_ERR_THR_LSB]),
        .trip_o     (trip),
        .count_o    (err_count)
    );

    // Lock state: gained on sync, dropped on counter trip.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            lock_reg <= DML_UNLOCKED;
        else
        begin
            case (lock_reg)
                DML_UNLOCKED:
                    if (SYNC_GAIN_I)
                        lock_reg <= DML_LOCKED;
                DML_LOCKED:
                    if (trip)
                        lock_reg <= DML_UNLOCKED;
                default:
                    lock_reg <= DML_UNLOCKED;
            endcase
        end
    end

    assign LOCK_O = lock_reg == DML_LOCKED;

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero.
    always_comb
    begin
        rdata_next = 8'h00;
        case (REG_ADDR_I)
            `DML_OFS_STRAP_STATUS: rdata_next = strap_reg;
            `DML_OFS_AUDIO_DIV:    rdata_next = aud_div_reg;
            `DML_OFS_EQUALIZER_SETTING_STATUS:
                rdata_next = {2'b00, second_port_select ?
                              EQ1_APPLIED_O : EQ0_APPLIED_O};
            `DML_OFS_LINK_ERR:     rdata_next = link_err_reg;
            `DML_OFS_DUAL_RX_CTL:  rdata_next = dual_rx_reg;
            `DML_OFS_EQ_BYPASS:
                rdata_next = second_port_select ? byp1_reg : byp0_reg;
            default:               rdata_next = 8'h00;
        endcase
    end

    // Registered read data, valid one cycle after the strobe.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= REG_RD_I;
            if (REG_RD_I)
                rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA_O  = rdata_reg;
    assign REG_RVALID_O = rvalid_reg;

endmodule // dml_mode_eq_regs

// ### dv/dml_host_model.sv
`timescale 1ns/1ps

// Host on the register bus: one request at a time, held to its taking edge.
module dml_host_model
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    // A released bus shows the inverse address; only a write also inverts its data.
    initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    // Returns the valid flag above the data seen one cycle after taking.
    task automatic rd(input logic [7:0] a, output logic [8:0] v);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        v = {rvalid_i, rdata_i};
    endtask
endmodule // dml_host_model

// ### dv/dml_mode_eq_regs_chk.sv
`timescale 1ns/1ps

module dml_mode_eq_regs_chk
(
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic       REG_WR_I,
    input wire logic       REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic       REG_RVALID_O,
    input wire logic [2:0] AUTO_AUD_DIV_I,
    input wire logic [1:0] AUTO_REF_DIV_I,
    input wire logic [2:0] AUD_DIV_SEL_O,
    input wire logic [5:0] AUD_DIV_RATIO_O,
    input wire logic [1:0] REF_DIV_SEL_O,
    input wire logic [3:0] REF_DIV_RATIO_O,
    input wire logic       SYNC_GAIN_I,
    input wire logic       CLK0_ERR_I,
    input wire logic       CLK1_ERR_I,
    input wire logic       DCB_ERR_I,
    input wire logic       LOCK_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic [7:0] aud_reg;
    logic [4:0] err_reg;
    logic [4:0] cnt_reg;
    wire        err = CLK0_ERR_I | CLK1_ERR_I | DCB_ERR_I;
    wire  [4:0] next_cnt = cnt_reg + 5'h01;
    wire        trip = LOCK_O && err
                       && (!err_reg[4] || next_cnt >= {1'b0, err_reg[3:0]});
    wire        unmapped = !(REG_ADDR_I inside
                             {8'h34, 8'h37, 8'h3A, 8'h3B, 8'h41, 8'h44});

    function automatic logic [5:0] aud_ratio(input logic [2:0] s);
        return (s > 3'h3) ? ((s > 3'h5) ? 6'h01 : 6'h02) : (6'h20 >> s);
    endfunction

    // Shadow of the audio divider register.
    always_ff @(posedge CLK_I)
        if (!RST_N_I)
            aud_reg <= 8'h00;
        else if (REG_WR_I && REG_ADDR_I == 8'h3A)
            aud_reg <= REG_WDATA_I;

    // Shadow of the error enable and threshold.
    always_ff @(posedge CLK_I)
        if (!RST_N_I)
            err_reg <= 5'h03;
        else if (REG_WR_I && REG_ADDR_I == 8'h41)
            err_reg <= REG_WDATA_I[4:0];

    // Expected error count: only while locked and enabled.
    always_ff @(posedge CLK_I)
        if (!RST_N_I || !LOCK_O || !err_reg[4])
            cnt_reg <= 5'h00;
        else if (err)
            cnt_reg <= next_cnt;

    ////////////////////////////////////////
    a_read_answer: assert property (
        RST_N_I |=> REG_RVALID_O == $past(REG_RD_I))
        else $error("Read valid did not follow the read strobe.");
    a_unmapped_zero: assert property (
        REG_RD_I && unmapped |=> REG_RDATA_O == 8'h00)
        else $error("Unmapped read returned nonzero data.");
    a_audio_select: assert property (
        RST_N_I |=> AUD_DIV_SEL_O == ($past(aud_reg[7]) ? $past(aud_reg[6:4])
                                : $past(AUTO_AUD_DIV_I)))
        else $error("Audio divider select ignores the override bit.");
    a_ref_select: assert property (
        RST_N_I |=> REF_DIV_SEL_O == ($past(aud_reg[2]) ? $past(aud_reg[1:0])
                                : $past(AUTO_REF_DIV_I)))
        else $error("Reference divider select ignores the override bit.");
    a_audio_ratio: assert property (
        AUD_DIV_RATIO_O == aud_ratio(AUD_DIV_SEL_O))
        else $error("Audio divide ratio does not match its select.");
    a_ref_ratio: assert property (
        REF_DIV_RATIO_O == (4'h1 << REF_DIV_SEL_O))
        else $error("Reference divide ratio does not match its select.");
    a_lock_gain: assert property (
        !LOCK_O && SYNC_GAIN_I |=> LOCK_O)
        else $error("Lock not taken after link sync.");
    a_drop_error: assert property (
        trip |=> !LOCK_O)
        else $error("Lock kept after the error that should drop it.");
    a_hold_below: assert property (
        LOCK_O && err && !trip |=> LOCK_O)
        else $error("Lock dropped below the error threshold.");

    c_counted_drop: cover property (trip && err_reg[4]);
    c_override: cover property (aud_reg[7] && aud_reg[2]);
    c_unmapped_read: cover property (REG_RD_I && unmapped);
endmodule // dml_mode_eq_regs_chk

bind dml_mode_eq_regs dml_mode_eq_regs_chk i_dml_mode_eq_regs_chk
(
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O), .AUTO_AUD_DIV_I(AUTO_AUD_DIV_I),
    .AUTO_REF_DIV_I(AUTO_REF_DIV_I), .AUD_DIV_SEL_O(AUD_DIV_SEL_O),
    .AUD_DIV_RATIO_O(AUD_DIV_RATIO_O), .REF_DIV_SEL_O(REF_DIV_SEL_O),
    .REF_DIV_RATIO_O(REF_DIV_RATIO_O), .SYNC_GAIN_I(SYNC_GAIN_I),
    .CLK0_ERR_I(CLK0_ERR_I), .CLK1_ERR_I(CLK1_ERR_I),
    .DCB_ERR_I(DCB_ERR_I), .LOCK_O(LOCK_O)
);

// ### dv/dml_mode_eq_regs_test.sv
`timescale 1ns/1ps

module dml_mode_eq_regs_test;
    import dml_pkg::*;

    logic       clk = 1'b0, rst_n = 1'b0, sync = 1'b0;
    logic       bc_v = 1'b0, out_v = 1'b0;
    logic       wr, rd, rvalid, lock, en0, en1;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] bc_c = 3'h0, out_c = 3'h0, auto_aud = 3'h0, errv = 3'h0;
    logic [1:0] auto_ref = 2'h0;
    logic [5:0] aud_rat, eq0, aeq0 = 6'h00, aeq1 = 6'h00;
    logic [3:0] ref_rat;
    logic [5:0] aud_tab [8] = '{6'h20, 6'h10, 6'h08, 6'h04,
                                6'h02, 6'h02, 6'h01, 6'h01};
    int         n_errors = 0, samples_checked = 0, cyc = 0;

    always #2.5 clk = ~clk;

    dml_mode_eq_regs i_dml_mode_eq_regs
    (
        .CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .BC_STRAP_VALID_I(bc_v),
        .BC_STRAP_CODE_I(bc_c), .OUT_STRAP_VALID_I(out_v),
        .OUT_STRAP_CODE_I(out_c), .AUTO_AUD_DIV_I(auto_aud),
        .AUTO_REF_DIV_I(auto_ref), .AUD_DIV_SEL_O(),
        .AUD_DIV_RATIO_O(aud_rat), .REF_DIV_SEL_O(),
        .REF_DIV_RATIO_O(ref_rat), .AEQ0_SETTING_I(aeq0),
        .AEQ1_SETTING_I(aeq1), .EQ0_APPLIED_O(eq0), .EQ1_APPLIED_O(),
        .AEQ0_ENABLE_O(en0), .AEQ1_ENABLE_O(en1), .SYNC_GAIN_I(sync),
        .CLK0_ERR_I(errv[0]), .CLK1_ERR_I(errv[1]), .DCB_ERR_I(errv[2]),
        .LOCK_O(lock)
    );

    dml_host_model i_dml_host_model
    (
        .clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr),
        .rd_o(rd), .addr_o(addr), .wdata_o(wdata)
    );

    ////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A hung bus or handshake ends the run as a failure.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input string n, input logic [8:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] v;
        i_dml_host_model.rd(a, v);
        chk($sformatf("register %h", a), {1'b1, e}, v);
    endtask

    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        bc_v <= 1'b0;
        out_v <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Register reset values, plus an unmapped place written and read.
    task automatic t_reset_values();
        rdc(8'h37, 8'h00);
        rdc(8'h3A, 8'h00);
        rdc(8'h3B, 8'h00);
        rdc(8'h41, 8'h03);
        rdc(8'h34, 8'h01);
        rdc(8'h44, 8'h60);
        i_dml_host_model.wr(8'h40, 8'hFF);
        rdc(8'h40, 8'h00);
    endtask

    // Every strap code latches once; later changes and writes are ignored.
    task automatic t_strap();
        for (int i = 0; i < 8; i++)
        begin
            do_reset();
            rdc(8'h37, 8'h00);
            bc_c <= 3'(i);
            out_c <= 3'(7 - i);
            bc_v <= 1'b1;
            out_v <= 1'b1;
            rdc(8'h37, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
            bc_c <= 3'(~i);
            out_c <= 3'(i);
            i_dml_host_model.wr(8'h37, 8'h00);
            rdc(8'h37, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
        end
    endtask

    // Overridden ratios for every code, then the automatic choice.
    task automatic t_div();
        for (int i = 0; i < 8; i++)
        begin
            i_dml_host_model.wr(8'h3A, {1'b1, 3'(i), 2'b11, 2'(i)});
            auto_aud <= 3'(~i);
            auto_ref <= 2'(~i);
            repeat (2) @(posedge clk);
            chk("audio ratio", {3'h0, aud_tab[i]}, {3'h0, aud_rat});
            chk("ref ratio", 9'h1 << i[1:0], {5'h0, ref_rat});
            rdc(8'h3A, {1'b1, 3'(i), 2'b01, 2'(i)});
        end
        i_dml_host_model.wr(8'h3A, 8'h70);
        auto_aud <= 3'h5;
        auto_ref <= 2'h3;
        repeat (2) @(posedge clk);
        chk("audio auto", 9'h002, {3'h0, aud_rat});
        chk("ref auto", 9'h008, {5'h0, ref_rat});
    endtask

    // Port 0 bypassed, port 1 adaptive, status steered by port select.
    task automatic t_eq();
        aeq0 <= 6'h3F;
        i_dml_host_model.wr(8'h44, 8'hB5);
        repeat (2) @(posedge clk);
        chk("eq0 enable", 9'h000, {8'h0, en0});
        chk("eq0 applied", 9'h015, {3'h0, eq0});
        rdc(8'h3B, 8'h15);
        rdc(8'h44, 8'hA5);
        aeq1 <= 6'h2A;
        i_dml_host_model.wr(8'h34, 8'h02);
        i_dml_host_model.wr(8'h44, 8'h62);
        rdc(8'h3B, 8'h2A);
        chk("eq1 enable", 9'h001, {8'h0, en1});
        rdc(8'h44, 8'h62);
        i_dml_host_model.wr(8'h34, 8'h01);
        rdc(8'h3B, 8'h15);
        rdc(8'h44, 8'hA5);
    endtask

    task automatic err(input int k);
        @(posedge clk) errv <= 3'(1 << k);
        @(posedge clk) errv <= 3'h0;
    endtask

    // First-error drop, then two rounds to a threshold of four.
    task automatic t_lock();
        i_dml_host_model.wr(8'h41, 8'h00);
        sync <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lock", 9'h001, {8'h0, lock});
        err(2);
        @(posedge clk);
        chk("lock", 9'h000, {8'h0, lock});
        i_dml_host_model.wr(8'h41, 8'hF4);
        rdc(8'h41, 8'h14);
        for (int i = 0; i < 8; i++)
        begin
            err(i % 3);
            @(posedge clk);
            chk("lock", {8'h0, i % 4 != 3}, {8'h0, lock});
            if (i % 4 == 3)
                repeat (2) @(posedge clk);
        end
    endtask

    initial
    begin
        do_reset();
        t_reset_values();
        t_strap();
        t_div();
        t_eq();
        t_lock();
        results();
    end
endmodule // dml_mode_eq_regs_test
